// *** src/pgel_map.svh ***
/*
 * offsets, field positions, reset values and timing figures of the
 * pre-driver gate enable logic.
 * assumes it is included by bare name wherever a figure is needed.
 */
`ifndef PGEL_MAP_SVH
`define PGEL_MAP_SVH

// ****************************************************************
// register map
// ****************************************************************
`define PGEL_ADDR_W 9
`define PGEL_SETUP_OFFSET 9'h1c5
`define PGEL_STATUS_OFFSET 9'h1c6
`define PGEL_SETUP_RESET 16'h0000
`define PGEL_READ_ZERO 16'h0000

// ****************************************************************
// fields of driver_setup_reg
// ****************************************************************
`define PGEL_BYPASS_BIT 0
`define PGEL_CLKMON_OFF_BIT 1
`define PGEL_HS_LOW_LSB 2
`define PGEL_HS_LOW_MSB 6

// ****************************************************************
// channel constants
// ****************************************************************
`define PGEL_BYPASS_CH_MASK 6'h24

// ****************************************************************
// timing
// ****************************************************************
`define PGEL_CLK_PERIOD_NS 4
`define PGEL_CP_INIT_NS 10000

`endif

// *** src/pgel_pkg.sv ***
/*
 * types shared by the pre-driver gate enable logic.
 * assumes nothing of its surroundings.
 */
package pgel_pkg;

   // charge pump sequencing states
   typedef enum logic [1:0]
   {
      PGEL_CP_OFF,
      PGEL_CP_INIT,
      PGEL_CP_READY
   } pgel_cp_state_e;

endpackage

// *** src/pgel_top.sv ***
/*
 * pre-driver gate enable logic: charge pump sequencing, high-side
 * gate forcing and low-side gate command forming, with one setup
 * register and one status register on a simple register port.
 * assumes every input is synchronous to i_ref_clk and that the
 * analog comparators deliver clean levels.
 */
`timescale 1ns/100ps
`include "pgel_map.svh"

// Contract
// - pump runs once supplies good, reset released
// - boost undervoltage disables all high-side gates
// - reset pin or enable low forces high gates
// - low bootstrap voltage never drives gate high
// - each source charges only below pump level
// - five independent per-channel pump sources
// - pump outputs valid after 10 us init
// - enable low forces low-side commands off
// - bypass bit frees channels 3, 6 from enable
// - either undervoltage flag forces low-side off
// - missing clock forces off, software can disable
// - command high only when every condition good
// - reset pin low pulls low-side gates down
// - high-side used low-side loses drain monitoring
// - low command pulls down, high pulls up
module pgel_top
#(
   parameter int HS_CH = 5,
   parameter int LS_CH = 6
)
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_power_on_reset_n,
   input wire logic i_reset_pin_n,
   input wire logic i_drv_en,
   input wire logic i_logic_supply_ok,
   input wire logic i_boost_supply_ok,
   input wire logic i_gate_supply_undervolt,
   input wire logic i_logic_supply_undervolt,
   input wire logic i_clock_ok,
   input wire logic [LS_CH-1:0] i_ls_request,
   input wire logic [HS_CH-1:0] i_hs_request,
   input wire logic [HS_CH-1:0] i_bootstrap_node_ok,
   input wire logic [HS_CH-1:0] i_bootstrap_node_below_cp,
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [`PGEL_ADDR_W-1:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   output logic [15:0] o_reg_rdata,
   output logic o_cp_run,
   output logic o_cp_ready,
   output logic [HS_CH-1:0] o_cp_src_en,
   output logic [HS_CH-1:0] o_high_gate_out,
   output logic [HS_CH-1:0] o_hs_vds_mon_valid,
   output logic [LS_CH-1:0] o_ls_command,
   output logic [LS_CH-1:0] o_ls_drive_high,
   output logic [LS_CH-1:0] o_ls_drive_low,
   output logic [LS_CH-1:0] o_ls_pulldown_en
);

   // ****************************************************************
   // constants
   // ****************************************************************
   // least time, so round up to whole cycles
   localparam int CP_INIT_CYC =
      (`PGEL_CP_INIT_NS + `PGEL_CLK_PERIOD_NS - 1) / `PGEL_CLK_PERIOD_NS;
   localparam int CNT_W = $clog2(CP_INIT_CYC + 1);
   localparam logic [CNT_W-1:0] CP_INIT_LAST = CNT_W'(CP_INIT_CYC - 1);
   localparam logic [LS_CH-1:0] BYPASS_MASK = `PGEL_BYPASS_CH_MASK;

   // ****************************************************************
   // functions
   // ****************************************************************
   // one low-side gate decision; bypass only lifts the enable term
   function automatic logic ls_gate
   (
      input logic req,
      input logic en_ok,
      input logic uv_any,
      input logic clk_ok
   );
      ls_gate = req & en_ok & ~uv_any & clk_ok;
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [15:0] driver_setup_reg;
   logic [15:0] driver_setup_next;
   logic [15:0] rdata_next;
   logic [15:0] status_word;
   pgel_pkg::pgel_cp_state_e cp_state_reg;
   pgel_pkg::pgel_cp_state_e cp_state_next;
   logic [CNT_W-1:0] cp_cnt_reg;
   logic [CNT_W-1:0] cp_cnt_next;
   logic [HS_CH-1:0] hs_req_reg;
   logic [LS_CH-1:0] ls_cmd_next;
   logic cp_cond;
   logic hs_allow;
   logic bypass_on;
   logic clkmon_off;
   logic uv_any;
   logic clk_ok_eff;
   logic [HS_CH-1:0] hs_low_cfg;
   logic sel_setup;
   logic sel_status;

   // ****************************************************************
   // register decode
   // ****************************************************************
   assign sel_setup = (i_reg_addr == `PGEL_SETUP_OFFSET);
   assign sel_status = (i_reg_addr == `PGEL_STATUS_OFFSET);
   assign driver_setup_next = (i_reg_wr_en && sel_setup) ? i_reg_wdata : driver_setup_reg;
   assign bypass_on = driver_setup_reg[`PGEL_BYPASS_BIT];
   assign clkmon_off = driver_setup_reg[`PGEL_CLKMON_OFF_BIT];
   assign hs_low_cfg = driver_setup_reg[`PGEL_HS_LOW_MSB:`PGEL_HS_LOW_LSB];

   // status shows live pump and gating state; unmapped reads give zero
   assign status_word = {3'h0, o_high_gate_out, o_cp_src_en, uv_any,
      clk_ok_eff, o_cp_ready};
   assign rdata_next = !i_reg_rd_en ? o_reg_rdata :
      sel_setup ? driver_setup_reg :
      sel_status ? status_word : `PGEL_READ_ZERO;

   // register storage and read data
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         driver_setup_reg <= `PGEL_SETUP_RESET;
         o_reg_rdata <= `PGEL_READ_ZERO;
      end
      else
      begin
         driver_setup_reg <= driver_setup_next;
         o_reg_rdata <= rdata_next;
      end
   end

   // ****************************************************************
   // charge pump sequencing
   // ****************************************************************
   // pump start conditions
   assign cp_cond = i_logic_supply_ok & i_boost_supply_ok & i_power_on_reset_n;

   // losing any start condition drops straight back to off
   always_comb
   begin
      cp_state_next = cp_state_reg;
      cp_cnt_next = cp_cnt_reg;
      case (cp_state_reg)
         pgel_pkg::PGEL_CP_OFF:
         begin
            cp_cnt_next = '0;
            if (cp_cond)
               cp_state_next = pgel_pkg::PGEL_CP_INIT;
         end
         pgel_pkg::PGEL_CP_INIT:
         begin
            if (!cp_cond)
               cp_state_next = pgel_pkg::PGEL_CP_OFF;
            else if (cp_cnt_reg == CP_INIT_LAST)
               cp_state_next = pgel_pkg::PGEL_CP_READY;
            else
               cp_cnt_next = cp_cnt_reg + 1'b1;
         end
         pgel_pkg::PGEL_CP_READY:
         begin
            if (!cp_cond)
               cp_state_next = pgel_pkg::PGEL_CP_OFF;
         end
         default:
            cp_state_next = pgel_pkg::PGEL_CP_OFF;
      endcase
   end

   // pump state flops
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         cp_state_reg <= pgel_pkg::PGEL_CP_OFF;
         cp_cnt_reg <= '0;
      end
      else
      begin
         cp_state_reg <= cp_state_next;
         cp_cnt_reg <= cp_cnt_next;
      end
   end

   // run also gated live so power-on reset stops it at once
   assign o_cp_run = (cp_state_reg != pgel_pkg::PGEL_CP_OFF) & cp_cond;
   assign o_cp_ready = (cp_state_reg == pgel_pkg::PGEL_CP_READY) & cp_cond;

   // sources stop once node is above pump level
   // one independent source per channel, whatever the drain supply
   assign o_cp_src_en = {HS_CH{o_cp_ready}} & i_bootstrap_node_below_cp;

   // ****************************************************************
   // high-side gates
   // ****************************************************************
   // request is sampled, the forcing terms act without a clock edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         hs_req_reg <= '0;
      else
         hs_req_reg <= i_hs_request;
   end

   // reset pin or enable low forces gates low at once
   assign hs_allow = i_boost_supply_ok & i_reset_pin_n & i_drv_en;
   // a weak bootstrap never lets a gate go high
   assign o_high_gate_out = hs_req_reg & {HS_CH{hs_allow}} & i_bootstrap_node_ok;

   // drain monitoring is meaningless on a channel used low-side
   assign o_hs_vds_mon_valid = ~hs_low_cfg;

   // ****************************************************************
   // low-side gate commands
   // ****************************************************************
   // either supply undervoltage
   assign uv_any = i_gate_supply_undervolt | i_logic_supply_undervolt;
   // clock monitor gating, software may switch it off
   assign clk_ok_eff = i_clock_ok | clkmon_off;

   // bypassed on channels 3 and 6 when the bit is set
   // bypass lifts only the enable term
   // high only with every condition good
   always_comb
   begin
      for (int i = 0; i < LS_CH; i++)
      begin
         ls_cmd_next[i] = ls_gate(i_ls_request[i],
            i_drv_en | (bypass_on & BYPASS_MASK[i]), uv_any, clk_ok_eff);
      end
   end

   // command held in flops for a clean gate edge
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         o_ls_command <= '0;
      else
         o_ls_command <= ls_cmd_next;
   end

   // low command sinks to ground, high sources from gate supply
   assign o_ls_drive_high = o_ls_command & {LS_CH{i_reset_pin_n}};
   assign o_ls_drive_low = ~o_ls_drive_high;
   // pull-down holds gates off while the reset pin is low
   assign o_ls_pulldown_en = {LS_CH{~i_reset_pin_n}};

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   // pump enters init with all conditions held
   sequence s_cp_enter;
      cp_cond && cp_state_reg == pgel_pkg::PGEL_CP_OFF;
   endsequence

   sequence s_cp_init_end;
      cp_cond && cp_state_reg == pgel_pkg::PGEL_CP_INIT && cp_cnt_reg == CP_INIT_LAST;
   endsequence

   a_cp_por_stop:
      assert property (!i_power_on_reset_n |-> !o_cp_run && !o_cp_ready)
      else $error("pump runs under power-on reset");

   a_cp_start:
      assert property (s_cp_enter ##1 cp_cond |-> o_cp_run && !o_cp_ready)
      else $error("pump did not start");

   a_cp_init_hold:
      assert property ($rose(o_cp_run) |-> !o_cp_ready [*8])
      else $error("pump ready too early");

   a_cp_init_done:
      assert property (s_cp_init_end ##1 cp_cond |-> o_cp_ready)
      else $error("pump not ready after init");

   a_cp_ready_cause:
      assert property ($rose(o_cp_ready) |-> $past(cp_cnt_reg) == CP_INIT_LAST)
      else $error("pump ready without full init");

   a_hs_uvlo_off:
      assert property (!i_boost_supply_ok |-> o_high_gate_out == '0)
      else $error("high gate on in boost undervoltage");

   a_hs_safe_force:
      assert property (!i_reset_pin_n || !i_drv_en |-> o_high_gate_out == '0)
      else $error("high gate not forced low");

   a_hs_weak_boot:
      assert property ((o_high_gate_out & ~i_bootstrap_node_ok) == '0)
      else $error("high gate on with weak bootstrap");

   a_hs_gate_follow:
      assert property (hs_allow && i_bootstrap_node_ok == '1
         |=> o_high_gate_out == ($past(i_hs_request) & i_bootstrap_node_ok)
            || !hs_allow)
      else $error("high gate lost its request");

   a_cp_src_stop:
      assert property ((o_cp_src_en & ~i_bootstrap_node_below_cp) == '0)
      else $error("source charges above pump level");

   a_cp_src_indep:
      assert property (o_cp_ready |-> o_cp_src_en == i_bootstrap_node_below_cp)
      else $error("source not independent per channel");

   a_vds_mon_cfg:
      assert property ((o_hs_vds_mon_valid & hs_low_cfg) == '0)
      else $error("drain monitor valid in low-side use");

   a_ls_enable_off:
      assert property (!i_drv_en |=> (o_ls_command & ~BYPASS_MASK) == '0)
      else $error("low-side on with enable low");

   a_ls_bypass_on:
      assert property (!i_drv_en && bypass_on && !uv_any && clk_ok_eff
         |=> (o_ls_command & BYPASS_MASK) == ($past(i_ls_request) & BYPASS_MASK))
      else $error("bypass channel ignored its request");

   a_ls_bypass_scope:
      assert property (uv_any || !clk_ok_eff |=> o_ls_command == '0)
      else $error("bypass let a fault through");

   a_ls_uv_off:
      assert property (i_gate_supply_undervolt || i_logic_supply_undervolt
         |=> o_ls_command == '0)
      else $error("low-side on in undervoltage");

   a_ls_clk_off:
      assert property (!i_clock_ok && !clkmon_off |=> o_ls_command == '0)
      else $error("low-side on with clock missing");

   a_ls_all_ok:
      assert property (i_drv_en && !uv_any && i_clock_ok
         |=> o_ls_command == $past(i_ls_request))
      else $error("low-side command wrong with all good");

   a_ls_reset_pd:
      assert property (!i_reset_pin_n |-> o_ls_pulldown_en == '1 && o_ls_drive_high == '0)
      else $error("low-side not held off in reset");

   a_ls_drive_pair:
      assert property ((o_ls_drive_high ^ o_ls_drive_low) == '1)
      else $error("low-side drive pair inconsistent");

endmodule

// *** verif/pgel_boot_model.sv ***
/*
 * behavioural bootstrap capacitors of the five high-side channels.
 * assumes source enables and discharge commands are synchronous
 * to i_ref_clk; discharge is held during reset to clear the levels.
 */
`timescale 1ns/100ps
module pgel_boot_model
(
   input wire logic i_ref_clk,
   input wire logic [4:0] i_src_en,
   input wire logic [4:0] i_discharge,
   output logic [4:0] o_node_ok,
   output logic [4:0] o_below_cp
);
   logic [2:0] lvl_reg [5];

   // ****************************************************************
   // charge state
   // ****************************************************************
   // charge below pump level
   always_ff @(posedge i_ref_clk)
   begin
      for (int c = 0; c < 5; c++)
      begin
         if (i_discharge[c])
            lvl_reg[c] <= 3'h0;
         else if (i_src_en[c] && lvl_reg[c] != 3'h7)
            lvl_reg[c] <= lvl_reg[c] + 3'h1;
      end
   end

   // level 7 stands for the pump voltage; a weak node is below 2
   always_comb
   begin
      for (int c = 0; c < 5; c++)
      begin
         o_node_ok[c] = lvl_reg[c] >= 3'h2;
         o_below_cp[c] = lvl_reg[c] != 3'h7;
      end
   end
endmodule

// *** verif/pgel_top_tb.sv ***
/*
 * self-checking bench of the pre-driver gate enable logic.
 * assumes the bootstrap model stands on the far side of the gates.
 */
`timescale 1ns/100ps
`include "pgel_map.svh"
module pgel_top_tb;
   logic i_ref_clk, i_srst, i_power_on_reset_n, i_reset_pin_n, i_drv_en;
   logic i_logic_supply_ok, i_boost_supply_ok, i_clock_ok, i_reg_wr_en, i_reg_rd_en;
   logic i_gate_supply_undervolt, i_logic_supply_undervolt, o_cp_run, o_cp_ready;
   logic [5:0] i_ls_request, o_ls_command, o_ls_drive_high, o_ls_drive_low, o_ls_pulldown_en;
   logic [4:0] i_hs_request, i_bootstrap_node_ok, i_bootstrap_node_below_cp, dis;
   logic [4:0] o_cp_src_en, o_high_gate_out, o_hs_vds_mon_valid;
   logic [8:0] i_reg_addr;
   logic [15:0] i_reg_wdata, o_reg_rdata, rd, ws;
   int seed = 11110;
   int miscompares = 0;
   int cmp_count = 0;
   int n;

   pgel_top dut (.i_ref_clk, .i_srst, .i_power_on_reset_n, .i_reset_pin_n, .i_drv_en,
      .i_logic_supply_ok, .i_boost_supply_ok, .i_gate_supply_undervolt,
      .i_logic_supply_undervolt, .i_clock_ok, .i_ls_request, .i_hs_request,
      .i_bootstrap_node_ok, .i_bootstrap_node_below_cp, .i_reg_wr_en, .i_reg_rd_en,
      .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_cp_run, .o_cp_ready, .o_cp_src_en,
      .o_high_gate_out, .o_hs_vds_mon_valid, .o_ls_command, .o_ls_drive_high,
      .o_ls_drive_low, .o_ls_pulldown_en);
   pgel_boot_model boot (.i_ref_clk, .i_src_en(o_cp_src_en), .i_discharge(dis),
      .o_node_ok(i_bootstrap_node_ok), .o_below_cp(i_bootstrap_node_below_cp));

   // ****************************************************************
   // helpers
   // ****************************************************************
   // free-running 250 MHz clock
   initial
   begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   // register port: one-cycle strobes, data valid a cycle after the read edge
   task automatic reg_wr(input logic [8:0] a, input logic [15:0] d);
      @(negedge i_ref_clk);
      i_reg_wr_en = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_ref_clk);
      i_reg_wr_en = 1'b0;
   endtask

   task automatic reg_rd(input logic [8:0] a, output logic [15:0] d);
      @(negedge i_ref_clk);
      i_reg_rd_en = 1'b1;
      i_reg_addr = a;
      @(negedge i_ref_clk);
      i_reg_rd_en = 1'b0;
      @(negedge i_ref_clk);
      d = o_reg_rdata;
   endtask

   // channels 3 and 6 (bits 2, 5) may skip only the enable gating
   function automatic logic [5:0] exp_ls(input logic [15:0] s);
      logic [5:0] en;
      en = {6{i_drv_en}} | ({6{s[`PGEL_BYPASS_BIT]}} & 6'h24);
      return i_ls_request & en & {6{~i_gate_supply_undervolt & ~i_logic_supply_undervolt
         & (i_clock_ok | s[`PGEL_CLKMON_OFF_BIT])}};
   endfunction

   // random pin levels, biased towards the enabled state
   task automatic drive_rand();
      logic [31:0] a, b;
      a = $random(seed);
      b = $random(seed);
      i_drv_en = a[0] | a[1];
      i_reset_pin_n = a[2] | a[3];
      i_gate_supply_undervolt = a[4] & a[5];
      i_logic_supply_undervolt = a[6] & a[7];
      i_clock_ok = a[8] | a[9];
      i_ls_request = a[15:10];
      i_hs_request = a[20:16];
      dis = b[4:0] & b[9:5] & b[14:10];
   endtask

   // stop a hung run well past the expected few thousand cycles
   initial
   begin
      #80000;
      miscompares++;
      report_and_stop();
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      {i_srst, i_logic_supply_ok, i_boost_supply_ok, i_reset_pin_n, i_drv_en} = 5'h1f;
      {i_power_on_reset_n, i_reg_wr_en, i_reg_rd_en, i_clock_ok} = 4'h1;
      {i_gate_supply_undervolt, i_logic_supply_undervolt} = 2'h0;
      {i_ls_request, i_hs_request, i_reg_addr, i_reg_wdata} = '0;
      dis = 5'h1f;
      repeat (5) @(negedge i_ref_clk);
      i_srst = 1'b0;
      reg_rd(9'h1c5, rd);
      chk(rd, 16'h0000, "setup reset");
      ws = $random(seed);
      reg_wr(9'h1c5, ws);
      reg_wr(9'h100, ~ws);
      reg_rd(9'h1c5, rd);
      chk(rd, ws, "setup rw");
      reg_rd(9'h000, rd);
      chk(rd, 16'h0000, "unmapped");
      $display("register test done");
      dis = 5'h00;
      i_power_on_reset_n = 1'b1;
      n = 0;
      while (o_cp_run !== 1'b1 && n < 10)
      begin
         @(negedge i_ref_clk);
         n++;
      end
      chk(n, 1, "pump start");
      n = 0;
      while (o_cp_ready !== 1'b1 && n < 3000)
      begin
         @(negedge i_ref_clk);
         n++;
      end
      chk(n == 2500 || n == 2501, 1, "pump init");
      chk(o_cp_src_en, 5'h1f, "src all");
      repeat (10) @(negedge i_ref_clk);
      chk(o_cp_src_en, 5'h00, "src stop");
      dis = 5'h04;
      @(negedge i_ref_clk);
      dis = 5'h00;
      @(negedge i_ref_clk);
      chk(o_cp_src_en, 5'h04, "src one");
      reg_rd(9'h1c6, rd);
      chk(rd, 16'h0023, "status word");
      $display("pump test done");
      for (int cfg = 0; cfg < 4; cfg++)
      begin
         ws = $random(seed);
         ws[`PGEL_BYPASS_BIT] = cfg[0];
         ws[`PGEL_CLKMON_OFF_BIT] = cfg[1];
         reg_wr(9'h1c5, ws);
         chk(o_hs_vds_mon_valid, 5'(~ws[6:2]), "vds valid");
         repeat (100)
         begin
            drive_rand();
            @(negedge i_ref_clk);
            chk(o_ls_command, exp_ls(ws), "ls cmd");
            chk(o_ls_drive_high, exp_ls(ws) & {6{i_reset_pin_n}}, "ls high");
            chk(o_ls_drive_low, 6'(~(exp_ls(ws) & {6{i_reset_pin_n}})), "ls low");
            chk(o_ls_pulldown_en, i_reset_pin_n ? 6'h00 : 6'h3f, "ls pulldown");
            chk(o_high_gate_out, i_hs_request & i_bootstrap_node_ok
               & {5{i_reset_pin_n & i_drv_en}}, "hs gate");
         end
      end
      $display("random gate test done");
      {i_drv_en, i_reset_pin_n, dis, i_hs_request} = {2'h3, 5'h00, 5'h1f};
      repeat (10) @(negedge i_ref_clk);
      chk(o_high_gate_out, 5'h1f, "hs on");
      i_boost_supply_ok = 1'b0;
      #1;
      chk(o_high_gate_out, 5'h00, "boost lockout");
      chk(o_cp_run, 1'b0, "boost stops pump");
      @(negedge i_ref_clk);
      {i_boost_supply_ok, i_power_on_reset_n} = 2'h2;
      #1;
      chk({o_cp_run, o_cp_ready}, 2'h0, "por stops pump");
      // missing logic supply alone must keep the pump stopped
      @(negedge i_ref_clk);
      {i_power_on_reset_n, i_logic_supply_ok} = 2'h2;
      repeat (2) @(negedge i_ref_clk);
      chk(o_cp_run, 1'b0, "logic supply stops pump");
      i_logic_supply_ok = 1'b1;
      repeat (2) @(negedge i_ref_clk);
      chk({o_cp_run, o_cp_ready}, 2'h2, "pump restarts");
      $display("safe state test done");
      report_and_stop();
   end
endmodule
